// ---- logic/ttp_edge_if.sv ----
`default_nettype none

interface ttp_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport det (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface

`default_nettype wire

// ---- logic/ttp_map.svh ----
`ifndef TTP_MAP_SVH
`define TTP_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define TTP_OFF_SEL0 8'h00
`define TTP_SEL_STRIDE 8'h04
`define TTP_OFF_MISC 8'h08
`define TTP_OFF_STAT 8'h0C

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define TTP_RESTART_BIT 0
`define TTP_STAT_PIN_LSB 16
`define TTP_LANE0 0
`define TTP_SEL_RESET 3'h0
`define TTP_PRESC_RESET 10'h000
`define TTP_WORD_ZERO 32'h0000_0000

// ----------------------------------------------------------------------
// prescaler tap positions (log2 of divisor) and sizes
// ----------------------------------------------------------------------
`define TTP_LOG_DIV8 3
`define TTP_LOG_DIV64 6
`define TTP_LOG_DIV256 8
`define TTP_LOG_DIV1024 10
`define TTP_PRESC_W 10
`define TTP_NUM_TIMERS 2
`define TTP_SEL_W 3

`endif

// ---- logic/ttp_pin_edge.sv ----
`default_nettype none

module ttp_pin_edge import ttp_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // external count pin
  input wire logic pin_i,
  // edge results
  ttp_edge_if.det edge_o
);

  // --------------------------------------------------------------------
  // synchroniser and edge detector
  // --------------------------------------------------------------------
  logic sync_a;
  logic sync_b;
  logic prev;

  // sync_a is read only by sync_b
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  assign edge_o.level = sync_b;
  assign edge_o.rise = sync_b & ~prev;
  assign edge_o.fall = ~sync_b & prev;

endmodule

`default_nettype wire

// ---- logic/ttp_pkg.sv ----
`default_nettype none

package ttp_pkg;

  // --------------------------------------------------------------------
  // tick source selection codes
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    TS_STOP     = 3'b000,
    TS_UNDIV    = 3'b001,
    TS_DIV8     = 3'b010,
    TS_DIV64    = 3'b011,
    TS_DIV256   = 3'b100,
    TS_DIV1024  = 3'b101,
    TS_EXT_FALL = 3'b110,
    TS_EXT_RISE = 3'b111
  } ttp_tick_source_t;

  typedef logic [31:0] ttp_word_t;

endpackage

`default_nettype wire

// ---- logic/ttp_tick_select.sv ----
// What this block does
// - select code one ticks the timer every system clock cycle.
// - four prescaler taps divide the clock by 8, 64, 256, 1024.
// - select decodes stop, undivided, four taps, falling pin, rising pin.
// - one free-running prescaler serves both timers, unaffected by selects.
// - first prescaled tick comes 1 to N cycles after enabling.
// - prescaler restart shifts the phase seen by every timer.
// - writing one restarts the prescaler; bit self-clears, reads zero.
// - each count pin is sampled every cycle, synchronised, edge detected.
// - synchroniser registers run on the rising system clock edge.
// - code 7 ticks on rising pin edges, code 6 on falling edges.
// - a pin edge reaches the timer a few cycles later, fixed delay.
// - pin ticks bypass the prescaler, never divided.
// - with no source selected no tick is delivered.
// - pin edges tick even when the pin is driven as an output.

`include "ttp_map.svh"

`default_nettype none

module ttp_tick_select import ttp_pkg::*; #(
  parameter int NUM_TIMERS = `TTP_NUM_TIMERS,
  parameter int PRESCALE_W = `TTP_PRESC_W,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // external count pins, sensed whatever the pin direction
  input wire logic [NUM_TIMERS-1:0] ext_count_pin_i,
  // one-cycle count enables to the timers
  output logic [NUM_TIMERS-1:0] timer_tick_o
);

  // --------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------
  if (NUM_TIMERS < 1 || NUM_TIMERS > `TTP_NUM_TIMERS) begin : g_bad_n
    $error("NUM_TIMERS must be 1 or 2");
  end
  if (PRESCALE_W != `TTP_LOG_DIV1024) begin : g_bad_w
    $error("PRESCALE_W must equal the widest tap");
  end
  if (ADDR_W < 8) begin : g_bad_a
    $error("ADDR_W too small for the register map");
  end

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  logic [ADDR_W-1:0] off_misc;
  logic [ADDR_W-1:0] off_stat;
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic hit_misc;
  logic hit_stat;
  logic hit_any;
  logic lane0_wr;
  logic restart_wr;
  logic [NUM_TIMERS-1:0] hit_sel;

  assign off_misc = ADDR_W'(`TTP_OFF_MISC);
  assign off_stat = ADDR_W'(`TTP_OFF_STAT);
  assign setup_phase = psel_i & ~penable_i;
  assign access_phase = psel_i & penable_i;
  assign wr_access = access_phase & pwrite_i;
  assign hit_misc = (paddr_i == off_misc);
  assign hit_stat = (paddr_i == off_stat);
  assign hit_any = (|hit_sel) | hit_misc | hit_stat;
  assign lane0_wr = wr_access & pstrb_i[`TTP_LANE0];

  // restart is a pulse: the bit has no storage, so it reads zero
  assign restart_wr = lane0_wr & hit_misc &
                      pwdata_i[`TTP_RESTART_BIT];

  // zero wait states; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = access_phase & ~hit_any;

  // --------------------------------------------------------------------
  // shared prescaler
  // --------------------------------------------------------------------
  logic [PRESCALE_W-1:0] presc;
  logic [PRESCALE_W-1:0] next_presc;
  logic [3:0] taps;

  // runs regardless of any select; only a restart disturbs it
  assign next_presc = restart_wr ? PRESCALE_W'(`TTP_PRESC_RESET)
                                 : presc + 1'b1;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      presc <= PRESCALE_W'(`TTP_PRESC_RESET);
    end else begin
      presc <= next_presc;
    end
  end

  // a tap fires on the last count of its period
  assign taps[0] = &presc[`TTP_LOG_DIV8-1:0];
  assign taps[1] = &presc[`TTP_LOG_DIV64-1:0];
  assign taps[2] = &presc[`TTP_LOG_DIV256-1:0];
  assign taps[3] = &presc[`TTP_LOG_DIV1024-1:0];

  // --------------------------------------------------------------------
  // source selection
  // --------------------------------------------------------------------
  function automatic logic pick_tick(input ttp_tick_source_t src,
                                     input logic [3:0] tap_v,
                                     input logic rise,
                                     input logic fall);
    logic t;
    t = 1'b0;
    unique case (src)
      TS_STOP: t = 1'b0;
      TS_UNDIV: t = 1'b1;
      TS_DIV8: t = tap_v[0];
      TS_DIV64: t = tap_v[1];
      TS_DIV256: t = tap_v[2];
      TS_DIV1024: t = tap_v[3];
      TS_EXT_FALL: t = fall;
      TS_EXT_RISE: t = rise;
    endcase
    return t;
  endfunction

  ttp_tick_source_t tick_source_select [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] next_tick;
  logic [NUM_TIMERS-1:0] pin_level;
  logic [31:0] sel_word [NUM_TIMERS];

  // --------------------------------------------------------------------
  // per-timer select register, detector and tick
  // --------------------------------------------------------------------
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    ttp_edge_if edge_bus ();
    logic [ADDR_W-1:0] off_sel;

    assign off_sel = ADDR_W'(`TTP_OFF_SEL0 + t * `TTP_SEL_STRIDE);
    assign hit_sel[t] = (paddr_i == off_sel);

    // own synchroniser per timer, prescaler shared
    ttp_pin_edge u_edge (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(ext_count_pin_i[t]),
      .edge_o(edge_bus.det)
    );

    assign pin_level[t] = edge_bus.level;
    assign next_tick[t] = pick_tick(tick_source_select[t], taps,
                                    edge_bus.rise, edge_bus.fall);
    assign sel_word[t] = hit_sel[t] ? 32'(tick_source_select[t])
                                    : `TTP_WORD_ZERO;

    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        tick_source_select[t] <= ttp_tick_source_t'(`TTP_SEL_RESET);
      end else if (lane0_wr && hit_sel[t]) begin
        tick_source_select[t] <=
          ttp_tick_source_t'(pwdata_i[`TTP_SEL_W-1:0]);
      end
    end

    // registered so the timer sees a clean one-cycle enable
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        timer_tick_o[t] <= 1'b0;
      end else begin
        timer_tick_o[t] <= next_tick[t];
      end
    end

    // ------------------------------------------------------------------
    // checks on the tick path
    // ------------------------------------------------------------------
    sequence s_rise_held;
      (tick_source_select[t] == TS_EXT_RISE && $rose(ext_count_pin_i[t]))
      ##1 (tick_source_select[t] == TS_EXT_RISE &&
           ext_count_pin_i[t]) [*2];
    endsequence

    sequence s_fall_held;
      (tick_source_select[t] == TS_EXT_FALL && $fell(ext_count_pin_i[t]))
      ##1 (tick_source_select[t] == TS_EXT_FALL &&
           !ext_count_pin_i[t]) [*2];
    endsequence

    a_stop_no_tick: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      tick_source_select[t] == TS_STOP |=> !timer_tick_o[t])
      else $error("tick while stopped");

    a_undiv_every_cycle: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      tick_source_select[t] == TS_UNDIV [*3] |=> timer_tick_o[t])
      else $error("undivided source missed a tick");

    a_div8_period: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (tick_source_select[t] == TS_DIV8 && !restart_wr && timer_tick_o[t])
      ##1 (tick_source_select[t] == TS_DIV8 && !restart_wr) [*7]
      |=> timer_tick_o[t])
      else $error("divide by 8 period wrong");

    a_div1024_tap: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      tick_source_select[t] == TS_DIV1024
      |=> timer_tick_o[t] == ($past(presc) == '1))
      else $error("divide by 1024 tap wrong");

    a_ext_rise_latency: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      s_rise_held |=> timer_tick_o[t])
      else $error("rising pin edge not ticked in time");

    a_ext_fall_latency: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      s_fall_held |=> timer_tick_o[t])
      else $error("falling pin edge not ticked in time");

    a_ext_single_pulse: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (tick_source_select[t] == TS_EXT_RISE &&
       $past(tick_source_select[t]) == TS_EXT_RISE && timer_tick_o[t])
      |=> !timer_tick_o[t])
      else $error("pin tick wider than one cycle");

    sequence s_fall_in_rise;
      (tick_source_select[t] == TS_EXT_RISE && $fell(ext_count_pin_i[t]))
      ##1 (tick_source_select[t] == TS_EXT_RISE &&
           !ext_count_pin_i[t]) [*2];
    endsequence

    sequence s_div8_restart;
      (tick_source_select[t] == TS_DIV8 && restart_wr)
      ##1 (tick_source_select[t] == TS_DIV8 && !restart_wr) [*8];
    endsequence

    a_rise_ignores_fall: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      s_fall_in_rise |=> !timer_tick_o[t])
      else $error("falling pin edge ticked in rising mode");

    a_restart_first_tick: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      s_div8_restart |=> timer_tick_o[t])
      else $error("first tick after restart not on time");

    a_sel_write_lands: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (lane0_wr && hit_sel[t])
      |=> tick_source_select[t] ==
          ttp_tick_source_t'($past(pwdata_i[`TTP_SEL_W-1:0])))
      else $error("select write did not land");

    a_strobe_masked: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (wr_access && !pstrb_i[`TTP_LANE0])
      |=> $stable(tick_source_select[t]))
      else $error("masked write changed the select");
  end

  // --------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------
  logic [31:0] stat_word;
  logic [31:0] sel_or;
  logic [31:0] rd_word;

  assign stat_word = 32'(presc) |
                     (32'(pin_level) << `TTP_STAT_PIN_LSB);

  always_comb begin
    sel_or = `TTP_WORD_ZERO;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      sel_or = sel_or | sel_word[i];
    end
  end

  // the restart bit always reads zero
  assign rd_word = sel_or |
                   (hit_stat ? stat_word : `TTP_WORD_ZERO);

  // captured in the setup phase, stable through the access phase
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_o <= `TTP_WORD_ZERO;
    end else if (setup_phase && !pwrite_i) begin
      prdata_o <= rd_word;
    end
  end

  // --------------------------------------------------------------------
  // checks on the prescaler and registers
  // --------------------------------------------------------------------
  a_presc_free_run: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !restart_wr |=> presc == PRESCALE_W'($past(presc) + 1'b1))
    else $error("prescaler did not advance");

  a_restart_clears: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    restart_wr |=> presc == PRESCALE_W'(`TTP_PRESC_RESET))
    else $error("restart did not clear prescaler");

  a_misc_reads_zero: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (setup_phase && !pwrite_i && hit_misc) |=> prdata_o == `TTP_WORD_ZERO)
    else $error("misc register read nonzero");

  a_unmapped_error: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (access_phase && !hit_any) |-> pslverr_o && pready_o)
    else $error("unmapped access without error");

  a_mapped_no_error: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (access_phase && hit_any) |-> !pslverr_o)
    else $error("mapped access flagged an error");

  a_shared_phase: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick_source_select[0] == TS_DIV8 &&
     tick_source_select[NUM_TIMERS-1] == TS_DIV8)
    |=> timer_tick_o[0] == timer_tick_o[NUM_TIMERS-1])
    else $error("timers on one tap out of phase");

endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
`include "ttp_map.svh"

`default_nettype none

module testbench import ttp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [1:0] pins, ticks;
  ttp_word_t pwdata, prdata, rd;
  int bad_count, n_checks, cyc, c0, c1, n;

  ttp_tick_select uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ext_count_pin_i(pins), .timer_tick_o(ticks));

  ttp_far_model far (.clk_i(clk_i), .timer_tick_i(ticks),
    .ext_count_pin_o(pins));

  always #2 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input ttp_word_t d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic check(input string name, input ttp_word_t seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic snap();
    c0 = far.tick_cnt[0];
    c1 = far.tick_cnt[1];
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, `TTP_OFF_SEL0, 32'h0);
    check("sel0 reset", rd, 32'h0);
    apb(1'b1, `TTP_OFF_SEL0, 32'h5);
    apb(1'b0, `TTP_OFF_SEL0, 32'h0);
    check("sel0 back", rd, 32'h5);
    pstrb <= 4'h0;
    apb(1'b1, `TTP_OFF_SEL0, 32'h3);
    pstrb <= 4'hF;
    apb(1'b0, `TTP_OFF_SEL0, 32'h0);
    check("masked write", rd, 32'h5);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", {31'h0, er}, 32'h1);
  endtask

  task automatic t_undiv();
    apb(1'b1, `TTP_OFF_SEL0, {29'h0, TS_UNDIV});
    apb(1'b1, `TTP_OFF_SEL0 + 8'h04, {29'h0, TS_STOP});
    wait_cyc(2);
    snap();
    wait_cyc(16);
    check("undiv ticks", far.tick_cnt[0] - c0, 32'h10);
    check("stopped ticks", far.tick_cnt[1] - c1, 32'h0);
  endtask

  task automatic t_div();
    int dv [4] = '{8, 64, 256, 1024};
    apb(1'b1, `TTP_OFF_SEL0 + 8'h04, {29'h0, TS_DIV8});
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `TTP_OFF_SEL0, 32'(i + 2));
      wait_cyc(2);
      snap();
      wait_cyc(2048);
      check("tap ticks", far.tick_cnt[0] - c0, 32'(2048 / dv[i]));
      check("shared /8", far.tick_cnt[1] - c1, 32'h100);
    end
  endtask

  task automatic t_restart();
    apb(1'b1, `TTP_OFF_SEL0, {29'h0, TS_DIV8});
    apb(1'b1, `TTP_OFF_MISC, 32'h1);
    n = 0;
    do begin
      wait_cyc(1);
      n++;
    end while (ticks[0] !== 1'b1 && n < 20);
    check("restart delay", 32'(n), 32'h8);
    check("both phases", {31'h0, ticks[1]}, 32'h1);
    apb(1'b0, `TTP_OFF_SEL0, 32'h0);
    check("sel0 div8", rd, 32'h2);
    apb(1'b0, `TTP_OFF_MISC, 32'h0);
    check("restart bit", rd, 32'h0);
  endtask

  task automatic t_pin();
    apb(1'b1, `TTP_OFF_SEL0, {29'h0, TS_EXT_RISE});
    apb(1'b1, `TTP_OFF_SEL0 + 8'h04, {29'h0, TS_EXT_FALL});
    wait_cyc(4);
    snap();
    fork
      far.toggle(0, 4);
      far.toggle(1, 5);
    join
    wait_cyc(6);
    check("rise ticks", far.tick_cnt[0] - c0, 32'h4);
    check("fall ticks", far.tick_cnt[1] - c1, 32'h5);
    far.edge_delay(0, n);
    check("pin delay", 32'(n), 32'h3);
    apb(1'b0, `TTP_OFF_STAT, 32'h0);
    check("pin level", 32'(rd[`TTP_STAT_PIN_LSB +: 2]), 32'h1);
    check("stat err", {31'h0, er}, 32'h0);
    far.edge_delay(0, n);
    check("no fall tick", 32'(n), 32'h8);
  endtask

  task automatic t_reset();
    apb(1'b1, `TTP_OFF_SEL0, {29'h0, TS_UNDIV});
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    snap();
    wait_cyc(8);
    check("ticks after reset", far.tick_cnt[0] - c0, 32'h0);
    apb(1'b0, `TTP_OFF_SEL0, 32'h0);
    check("sel0 after reset", rd, 32'h0);
  endtask

  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_undiv();
    t_div();
    t_restart();
    t_pin();
    t_reset();
    end_sim();
  end
endmodule

`default_nettype wire

// ---- verification/ttp_far_model.sv ----
`default_nettype none

module ttp_far_model import ttp_pkg::*; (
  // clock
  input wire logic clk_i,
  // count enables in, count pins out
  input wire logic [1:0] timer_tick_i,
  output logic [1:0] ext_count_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int tick_cnt [2];

  initial begin
    ext_count_pin_o = 2'h0;
    tick_cnt[0] = 0;
    tick_cnt[1] = 0;
  end

  // ----------------------------------------------------------------
  // two timer units that only count the enables they receive
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    for (int t = 0; t < 2; t++) begin
      if (timer_tick_i[t] === 1'b1) begin
        tick_cnt[t]++;
      end
    end
  end

  // full pin periods, each half three clock cycles long
  task automatic toggle(input int t, input int n);
    repeat (2 * n) begin
      @(posedge clk_i);
      ext_count_pin_o[t] <= ~ext_count_pin_o[t];
      repeat (2) @(posedge clk_i);
    end
  endtask

  // one pin edge, then cycles until a tick shows (8 means none)
  task automatic edge_delay(input int t, output int n);
    @(posedge clk_i);
    ext_count_pin_o[t] <= ~ext_count_pin_o[t];
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (timer_tick_i[t] !== 1'b1 && n < 8);
  endtask
endmodule

`default_nettype wire
